// ==== verilog/sass_pkg.sv ====
// Constants, register map and state encoding of the scan sequencer
`default_nettype none

package sass_pkg;

  // Clock rates, converter timing, channel count and buffer sizes
  localparam int unsigned SYS_CLK_HZ      = 250_000_000;
  localparam int unsigned SAR_CLK_MAX_HZ  = 18_000_000;
  localparam int unsigned SAR_DIV         = (SYS_CLK_HZ + SAR_CLK_MAX_HZ - 1) / SAR_CLK_MAX_HZ;
  localparam int unsigned SAR_DIV_HALF    = SAR_DIV / 2;
  localparam int unsigned RES_BITS        = 12;
  localparam int unsigned CONV_MIN_CLKS   = 18;
  localparam int unsigned SAMPLE_MIN_CLKS = CONV_MIN_CLKS - RES_BITS;
  localparam int unsigned NUM_CH          = 8;
  localparam int unsigned CH_W            = 3;
  localparam int unsigned SAMP_EXT_W      = 8;
  localparam int unsigned FIFO_DEPTH      = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_CHEN        = 8'h04;
  localparam logic [7:0] ADDR_FWSEL       = 8'h08;
  localparam logic [7:0] ADDR_LIM_LO      = 8'h0C;
  localparam logic [7:0] ADDR_LIM_HI      = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;
  localparam logic [7:0] ADDR_RANGE       = 8'h18;
  localparam logic [7:0] ADDR_FIFO        = 8'h1C;
  localparam logic [7:0] ADDR_SAMPLE_BASE = 8'h20;
  localparam logic [7:0] ADDR_RESULT_BASE = 8'h40;
  localparam logic [7:0] ADDR_STRIDE      = 8'h04;

  // Field positions
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_FW_BIT     = 1;
  localparam int unsigned CTRL_FIFO_BIT   = 2;
  localparam int unsigned FWSEL_START_BIT = 8;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_CH_LSB     = 2;
  localparam int unsigned STAT_NEMPTY_BIT = 5;
  localparam int unsigned STAT_FULL_BIT   = 6;
  localparam int unsigned STAT_SLEEP_BIT  = 7;
  localparam int unsigned WORD_CH_LSB     = 12;
  localparam int unsigned WORD_VALID_BIT  = 16;

  // Reset values
  localparam logic [7:0]  CHEN_RST        = 8'h00;
  localparam logic [11:0] LIM_LO_RST      = 12'h000;
  localparam logic [11:0] LIM_HI_RST      = 12'hFFF;
  localparam logic [7:0]  SAMP_EXT_RST    = 8'h00;

  typedef enum logic [1:0] {
    SASS_IDLE    = 2'b00,
    SASS_SAMPLE  = 2'b01,
    SASS_CONVERT = 2'b10
  } sass_state_t;

endpackage : sass_pkg

`default_nettype wire

// ==== verilog/sass_fifo.sv ====
// Result FIFO with registered head word
`default_nettype none

module sass_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned LW    = $clog2(DEPTH + 1)
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic [LW-1:0]         level_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [LW-1:0]    count_r;
  logic [WIDTH-1:0] head_r;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] sass_inc(input logic [AW-1:0] p);
    sass_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : sass_inc

  assign in_ready_o  = (count_r != LW'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign rd_ptr_nxt  = pop ? sass_inc(rd_ptr_r) : rd_ptr_r;
  assign out_data_o  = head_r;
  assign level_o     = count_r;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= sass_inc(wr_ptr_r);
      end
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_r + LW'(push) - LW'(pop);
    end
  end

  // Head word is prefetched so the read side sees a flop, with bypass when empty
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      head_r <= '0;
    end else if (push && (wr_ptr_r == rd_ptr_nxt)) begin
      head_r <= in_data_i;
    end else begin
      head_r <= mem[rd_ptr_nxt];
    end
  end

endmodule : sass_fifo

`default_nettype wire

// ==== verilog/sass_scan_seq.sv ====
// Successive-approximation converter control with eight-channel scan sequencer
//
// Overview of operation
// - Twelve-bit results, aggregate rate one megasample
// - Converter clock at most 18 MHz, 18 clocks
// - Select one of eight fixed input channels
// - Scan enabled channels repeatedly without software
// - Channel switch adds no extra converter clocks
// - Channel chosen by sequencer or by firmware
// - Separate result register for every channel
// - Per-channel sample time, current channel applied
// - Sample window programmable by software
// - Programmable low and high range limits
// - Out-of-range result raises interrupt request
// - Range check on each result immediately
// - Inactive during deep sleep
`default_nettype none

module sass_scan_seq (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  input  wire logic        deep_sleep_i,
  input  wire logic        cmp_i,
  output logic             sar_clk_o,
  output logic [2:0]       chan_sel_o,
  output logic             sample_o,
  output logic [11:0]      dac_code_o,
  output logic             range_irq_o,
  output logic             scan_done_o
);

  localparam int unsigned NCH = sass_pkg::NUM_CH;
  localparam int unsigned CW  = sass_pkg::CH_W;
  localparam int unsigned RB  = sass_pkg::RES_BITS;
  localparam int unsigned FW  = RB + CW;
  localparam int unsigned FLW = $clog2(sass_pkg::FIFO_DEPTH + 1);

  sass_pkg::sass_state_t state_r, state_nxt;

  logic             ctrl_en_r, ctrl_fw_r, ctrl_fifo_r;
  logic [NCH-1:0]   chen_r;
  logic [CW-1:0]    fw_ch_r;
  logic             fw_pend_r;
  logic [RB-1:0]    lim_lo_r, lim_hi_r;
  logic [sass_pkg::SAMP_EXT_W-1:0] samp_ext_r [NCH];
  logic [RB-1:0]    result_r [NCH];
  logic [NCH-1:0]   res_valid_r;
  logic [NCH-1:0]   range_flag_r;
  logic             scan_done_r;
  logic [CW-1:0]    cur_ch_r, ch_nxt;
  logic [4:0]       div_cnt_r;
  logic             tick;
  logic [8:0]       samp_cnt_r;
  logic [8:0]       samp_len;
  logic [3:0]       bit_idx_r;
  logic [RB-1:0]    dac_r;
  logic [RB-1:0]    res_word;
  logic             sar_clk_r, sample_r;
  logic             cmp_s1_r, cmp_s2_r, cmp_s3_r, cmp_val_r;
  logic             finish, out_of_range, scan_wrap, start_fw;
  logic [CW:0]      nxt_info, first_info;
  logic             fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [FW-1:0]    fifo_out_data;
  logic [FLW-1:0]   fifo_level;
  logic             room_idle, room_cont;
  logic [31:0]      rd_mux;

  // Next enabled channel after cur, with a flag when the search wrapped past the top
  function automatic logic [CW:0] sass_next(input logic [NCH-1:0] en,
                                            input logic [CW-1:0] cur);
    logic [CW:0] r;
    logic        found;
    int          idx;
    r     = {1'b1, cur};
    found = 1'b0;
    for (int k = 1; k <= int'(NCH); k++) begin
      idx = (int'(cur) + k) % int'(NCH);
      if (!found && en[idx]) begin
        found = 1'b1;
        r     = {((int'(cur) + k) >= int'(NCH)), CW'(idx)};
      end
    end
    return r;
  endfunction : sass_next

  // Comparator is asynchronous to the logic; value moves only when stages 2 and 3 agree
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmp_s1_r  <= 1'b0;
      cmp_s2_r  <= 1'b0;
      cmp_s3_r  <= 1'b0;
      cmp_val_r <= 1'b0;
    end else begin
      cmp_s1_r <= cmp_i;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      if (cmp_s2_r == cmp_s3_r) begin
        cmp_val_r <= cmp_s3_r;
      end
    end
  end

  // Converter clock: divider chosen so the rate never exceeds the limit
  assign tick = (div_cnt_r == 5'(sass_pkg::SAR_DIV - 1));
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || state_r == sass_pkg::SASS_IDLE || deep_sleep_i) begin
      div_cnt_r <= '0;
      sar_clk_r <= 1'b0;
    end else begin
      div_cnt_r <= tick ? '0 : div_cnt_r + 5'h01;
      sar_clk_r <= (div_cnt_r < 5'(sass_pkg::SAR_DIV_HALF));
    end
  end

  // Sample time of the channel being converted
  assign samp_len = 9'(sass_pkg::SAMPLE_MIN_CLKS) + 9'(samp_ext_r[cur_ch_r]);

  // Bit trial: keep the trial bit when the input is above the DAC level
  always_comb begin
    res_word            = dac_r;
    res_word[bit_idx_r] = cmp_val_r;
  end

  assign finish       = (state_r == sass_pkg::SASS_CONVERT) && tick && (bit_idx_r == 4'h0);
  assign out_of_range = (res_word < lim_lo_r) || (res_word > lim_hi_r);
  assign nxt_info     = sass_next(chen_r, cur_ch_r);
  assign first_info   = sass_next(chen_r, CW'(NCH - 1));
  assign scan_wrap    = nxt_info[CW];
  // A conversion only starts with a free slot, so its result is never dropped
  assign room_idle    = !ctrl_fifo_r || fifo_in_ready;
  assign room_cont    = !ctrl_fifo_r || (fifo_level < FLW'(sass_pkg::FIFO_DEPTH - 1));
  assign start_fw     = ctrl_en_r && ctrl_fw_r && fw_pend_r && room_idle;

  always_comb begin
    state_nxt = state_r;
    ch_nxt    = cur_ch_r;
    case (state_r)
      sass_pkg::SASS_IDLE: begin
        if (start_fw) begin
          state_nxt = sass_pkg::SASS_SAMPLE;
          ch_nxt    = fw_ch_r;
        end else if (ctrl_en_r && !ctrl_fw_r && (|chen_r) && room_idle) begin
          state_nxt = sass_pkg::SASS_SAMPLE;
          ch_nxt    = first_info[CW-1:0];
        end
      end
      sass_pkg::SASS_SAMPLE: begin
        if (tick && (samp_cnt_r == samp_len - 9'h001)) begin
          state_nxt = sass_pkg::SASS_CONVERT;
        end
      end
      sass_pkg::SASS_CONVERT: begin
        if (finish) begin
          // Next sample starts on the very next converter clock
          if (ctrl_en_r && !ctrl_fw_r && (|chen_r) && room_cont) begin
            state_nxt = sass_pkg::SASS_SAMPLE;
            ch_nxt    = nxt_info[CW-1:0];
          end else begin
            state_nxt = sass_pkg::SASS_IDLE;
          end
        end
      end
      default: begin
        state_nxt = sass_pkg::SASS_IDLE;
      end
    endcase
    if (deep_sleep_i) begin
      state_nxt = sass_pkg::SASS_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r  <= sass_pkg::SASS_IDLE;
      cur_ch_r <= '0;
      sample_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cur_ch_r <= ch_nxt;
      sample_r <= (state_nxt == sass_pkg::SASS_SAMPLE);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      samp_cnt_r <= '0;
      bit_idx_r  <= '0;
      dac_r      <= '0;
    end else if (state_r != sass_pkg::SASS_SAMPLE && state_nxt == sass_pkg::SASS_SAMPLE) begin
      samp_cnt_r <= '0;
    end else if (state_r == sass_pkg::SASS_SAMPLE && state_nxt == sass_pkg::SASS_CONVERT) begin
      bit_idx_r  <= 4'(RB - 1);
      dac_r      <= {1'b1, {(RB - 1){1'b0}}};
    end else if (finish) begin
      samp_cnt_r <= '0;
      dac_r      <= res_word;
    end else if (tick && state_r == sass_pkg::SASS_SAMPLE) begin
      samp_cnt_r <= samp_cnt_r + 9'h001;
    end else if (tick && state_r == sass_pkg::SASS_CONVERT) begin
      dac_r                    <= res_word;
      dac_r[bit_idx_r - 4'h1]  <= 1'b1;
      bit_idx_r                <= bit_idx_r - 4'h1;
    end
  end

  // Bus writes to control registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_en_r   <= 1'b0;
      ctrl_fw_r   <= 1'b0;
      ctrl_fifo_r <= 1'b0;
      chen_r      <= sass_pkg::CHEN_RST;
      fw_ch_r     <= '0;
      lim_lo_r    <= sass_pkg::LIM_LO_RST;
      lim_hi_r    <= sass_pkg::LIM_HI_RST;
    end else if (wr_i) begin
      if (addr_i == sass_pkg::ADDR_CTRL) begin
        ctrl_en_r   <= wdata_i[sass_pkg::CTRL_EN_BIT];
        ctrl_fw_r   <= wdata_i[sass_pkg::CTRL_FW_BIT];
        ctrl_fifo_r <= wdata_i[sass_pkg::CTRL_FIFO_BIT];
      end
      if (addr_i == sass_pkg::ADDR_CHEN) begin
        chen_r <= wdata_i[NCH-1:0];
      end
      if (addr_i == sass_pkg::ADDR_FWSEL) begin
        fw_ch_r <= wdata_i[CW-1:0];
      end
      if (addr_i == sass_pkg::ADDR_LIM_LO) begin
        lim_lo_r <= wdata_i[RB-1:0];
      end
      if (addr_i == sass_pkg::ADDR_LIM_HI) begin
        lim_hi_r <= wdata_i[RB-1:0];
      end
    end
  end

  // Firmware start request waits until the sequencer is idle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fw_pend_r <= 1'b0;
    end else if (wr_i && addr_i == sass_pkg::ADDR_FWSEL &&
                 wdata_i[sass_pkg::FWSEL_START_BIT]) begin
      fw_pend_r <= 1'b1;
    end else if (start_fw && state_r == sass_pkg::SASS_IDLE && !deep_sleep_i) begin
      fw_pend_r <= 1'b0;
    end
  end

  // Completed scans; hardware set wins over a same-cycle clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      scan_done_r <= 1'b0;
    end else if (finish && !ctrl_fw_r && scan_wrap) begin
      scan_done_r <= 1'b1;
    end else if (wr_i && addr_i == sass_pkg::ADDR_STATUS && wdata_i[sass_pkg::STAT_DONE_BIT]) begin
      scan_done_r <= 1'b0;
    end
  end

  for (genvar g = 0; g < int'(NCH); g++) begin : g_ch
    localparam logic [7:0] OFS = 8'(g) * sass_pkg::ADDR_STRIDE;
    logic hit;
    assign hit = finish && (cur_ch_r == CW'(g));

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        samp_ext_r[g] <= sass_pkg::SAMP_EXT_RST;
      end else if (wr_i && addr_i == sass_pkg::ADDR_SAMPLE_BASE + OFS) begin
        samp_ext_r[g] <= wdata_i[sass_pkg::SAMP_EXT_W-1:0];
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        result_r[g]    <= '0;
        res_valid_r[g] <= 1'b0;
      end else if (hit) begin
        result_r[g]    <= res_word;
        res_valid_r[g] <= 1'b1;
      end else if (rd_i && addr_i == sass_pkg::ADDR_RESULT_BASE + OFS) begin
        res_valid_r[g] <= 1'b0;
      end
    end

    // Checked per result, not per scan; write one to clear
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        range_flag_r[g] <= 1'b0;
      end else if (hit && out_of_range) begin
        range_flag_r[g] <= 1'b1;
      end else if (wr_i && addr_i == sass_pkg::ADDR_RANGE && wdata_i[g]) begin
        range_flag_r[g] <= 1'b0;
      end
    end
  end

  // Software drains the FIFO by reading its window; a full FIFO holds the scan back
  assign fifo_pop = rd_i && (addr_i == sass_pkg::ADDR_FIFO);

  sass_fifo #(
    .WIDTH (FW),
    .DEPTH (sass_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (finish && ctrl_fifo_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({cur_ch_r, res_word}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level)
  );

  always_comb begin
    rd_mux = '0;
    case (addr_i)
      sass_pkg::ADDR_CTRL: begin
        rd_mux[sass_pkg::CTRL_EN_BIT]   = ctrl_en_r;
        rd_mux[sass_pkg::CTRL_FW_BIT]   = ctrl_fw_r;
        rd_mux[sass_pkg::CTRL_FIFO_BIT] = ctrl_fifo_r;
      end
      sass_pkg::ADDR_CHEN:   rd_mux[NCH-1:0] = chen_r;
      sass_pkg::ADDR_FWSEL: begin
        rd_mux[CW-1:0]                    = fw_ch_r;
        rd_mux[sass_pkg::FWSEL_START_BIT] = fw_pend_r;
      end
      sass_pkg::ADDR_LIM_LO: rd_mux[RB-1:0] = lim_lo_r;
      sass_pkg::ADDR_LIM_HI: rd_mux[RB-1:0] = lim_hi_r;
      sass_pkg::ADDR_STATUS: begin
        rd_mux[sass_pkg::STAT_BUSY_BIT]                    = (state_r != sass_pkg::SASS_IDLE);
        rd_mux[sass_pkg::STAT_DONE_BIT]                    = scan_done_r;
        rd_mux[sass_pkg::STAT_CH_LSB +: CW]                = cur_ch_r;
        rd_mux[sass_pkg::STAT_NEMPTY_BIT]                  = fifo_out_valid;
        rd_mux[sass_pkg::STAT_FULL_BIT]                    = !fifo_in_ready;
        rd_mux[sass_pkg::STAT_SLEEP_BIT]                   = deep_sleep_i;
      end
      sass_pkg::ADDR_RANGE:  rd_mux[NCH-1:0] = range_flag_r;
      sass_pkg::ADDR_FIFO: begin
        rd_mux[FW-1:0]                   = fifo_out_valid ? fifo_out_data : '0;
        rd_mux[sass_pkg::WORD_VALID_BIT] = fifo_out_valid;
      end
      default: begin
        for (int i = 0; i < int'(NCH); i++) begin
          if (addr_i == sass_pkg::ADDR_SAMPLE_BASE + 8'(i) * sass_pkg::ADDR_STRIDE) begin
            rd_mux[sass_pkg::SAMP_EXT_W-1:0] = samp_ext_r[i];
          end
          if (addr_i == sass_pkg::ADDR_RESULT_BASE + 8'(i) * sass_pkg::ADDR_STRIDE) begin
            rd_mux[RB-1:0]                   = result_r[i];
            rd_mux[sass_pkg::WORD_CH_LSB +: CW] = CW'(i);
            rd_mux[sass_pkg::WORD_VALID_BIT] = res_valid_r[i];
          end
        end
      end
    endcase
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end

  assign sar_clk_o   = sar_clk_r;
  assign chan_sel_o  = cur_ch_r;
  assign sample_o    = sample_r;
  assign dac_code_o  = dac_r;
  assign range_irq_o = |range_flag_r;
  assign scan_done_o = scan_done_r;

endmodule : sass_scan_seq

`default_nettype wire

// ==== tb/sass_analog_model.sv ====
// Behavioural analog inputs and comparator behind the channel mux
`default_nettype none

module sass_analog_model (
  input  wire logic        sys_clk_i,
  input  wire logic [2:0]  chan_sel_i,
  input  wire logic        sample_i,
  input  wire logic [11:0] dac_code_i,
  input  wire logic [11:0] level_i [8],
  output logic             cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [11:0] held_r;

  // Hold cap tracks the selected pin only while acquiring
  always_ff @(posedge sys_clk_i) begin
    if (sample_i) begin
      held_r <= level_i[chan_sel_i];
    end
  end

  // Ideal comparator: equal counts as above, so the result floors
  assign cmp_o = (held_r >= dac_code_i);

endmodule : sass_analog_model

`default_nettype wire

// ==== tb/sass_scan_seq_sva.sv ====
// Port assertions of the scan sequencer
`default_nettype none

module sass_scan_seq_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        deep_sleep_i,
  input wire logic        cmp_i,
  input wire logic        sar_clk_o,
  input wire logic [2:0]  chan_sel_o,
  input wire logic        sample_o,
  input wire logic [11:0] dac_code_o,
  input wire logic        range_irq_o,
  input wire logic        scan_done_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  localparam int unsigned MIN_SAMP = sass_pkg::SAMPLE_MIN_CLKS * sass_pkg::SAR_DIV;
  logic [15:0] samp_len;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !sample_o) samp_len <= 16'h0000;
    else samp_len <= samp_len + 16'h0001;
  end

  sleep_idle_a: assert property (deep_sleep_i ##1 deep_sleep_i |-> !sample_o && !sar_clk_o)
    else $error("converter active in deep sleep");
  clk_high_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || deep_sleep_i)
    $rose(sar_clk_o) |-> sar_clk_o [*7] ##1 !sar_clk_o) else $error("bad high phase");
  clk_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || deep_sleep_i)
    $fell(sar_clk_o) |-> !sar_clk_o [*7]) else $error("converter clock too fast");
  chan_hold_a: assert property (sample_o && $past(sample_o) |-> $stable(chan_sel_o))
    else $error("channel moved while sampling");
  samp_len_a: assert property ($fell(sample_o) && !deep_sleep_i |->
    samp_len >= MIN_SAMP && samp_len % sass_pkg::SAR_DIV == 0) else $error("bad sample window");
  msb_trial_a: assert property ($fell(sample_o) && !deep_sleep_i |-> dac_code_o == 12'h800)
    else $error("first trial not the top bit");
  irq_hold_a: assert property (range_irq_o && !(wr_i && addr_i == sass_pkg::ADDR_RANGE)
    |=> range_irq_o) else $error("range request dropped");
  done_hold_a: assert property (scan_done_o && !(wr_i && addr_i == sass_pkg::ADDR_STATUS)
    |=> scan_done_o) else $error("scan done dropped");
  rdata_zero_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");

  cover property ($rose(range_irq_o));
  cover property ($rose(scan_done_o));
  cover property ($fell(sample_o) && !deep_sleep_i);
  cover property (deep_sleep_i && $past(sample_o));

endmodule : sass_scan_seq_chk

bind sass_scan_seq sass_scan_seq_chk i_sass_scan_seq_chk (.sys_clk_i, .rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .deep_sleep_i, .cmp_i, .sar_clk_o, .chan_sel_o,
  .sample_o, .dac_code_o, .range_irq_o, .scan_done_o);

`default_nettype wire

// ==== tb/sass_scan_seq_test.sv ====
// Self-checking testbench of the scan sequencer
`default_nettype none

module sass_scan_seq_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [2:0]  ch;
    logic [7:0]  ext;
    logic [11:0] lo;
    logic [11:0] hi;
  } sass_row_t;

  localparam sass_row_t ROWS [6] = '{
    '{3'h0, 8'h00, 12'h000, 12'hFFF}, '{3'h3, 8'h02, 12'h000, 12'hFFE},
    '{3'h5, 8'h00, 12'h556, 12'hFFF}, '{3'h6, 8'h01, 12'hA5A, 12'hA5A},
    '{3'h7, 8'h00, 12'h800, 12'hFFF}, '{3'h1, 8'h00, 12'h000, 12'h7FF}};
  localparam int unsigned CONV =
    (sass_pkg::SAMPLE_MIN_CLKS + sass_pkg::RES_BITS) * sass_pkg::SAR_DIV;

  logic        sys_clk_i, rst_i, wr_i, rd_i, deep_sleep_i, cmp_i, e;
  logic        sar_clk_o, sample_o, range_irq_o, scan_done_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [2:0]  chan_sel_o;
  logic [11:0] dac_code_o;
  logic [11:0] lvl [8] = '{12'h000, 12'h800, 12'h123, 12'hFFF, 12'h3C3, 12'h555, 12'hA5A, 12'h7FF};
  int          miscompares, checked, n, cnt;

  sass_scan_seq i_sass_scan_seq (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .deep_sleep_i(deep_sleep_i),
    .cmp_i(cmp_i), .sar_clk_o(sar_clk_o), .chan_sel_o(chan_sel_o), .sample_o(sample_o),
    .dac_code_o(dac_code_o), .range_irq_o(range_irq_o), .scan_done_o(scan_done_o));
  sass_analog_model i_sass_analog_model (.sys_clk_i(sys_clk_i), .chan_sel_i(chan_sel_o),
    .sample_i(sample_o), .dac_code_i(dac_code_o), .level_i(lvl), .cmp_o(cmp_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    @(negedge sys_clk_i);
    v = rdata_o;
  endtask : rd

  // Bounded poll; a stuck bit counts as a miscompare once the limit is reached
  task automatic poll(input logic [7:0] a, input int b, input logic lv);
    cnt = 0;
    rd(a, d);
    while (d[b] !== lv && cnt < 3000) begin
      rd(a, d);
      cnt++;
    end
    if (cnt >= 3000) miscompares++;
  endtask : poll

  // Counts cycles up to the next rising edge of the sample phase
  task automatic wait_samp(output int k);
    k = 0;
    while (sample_o !== 1'b0 && k < 2000) begin
      @(negedge sys_clk_i);
      k++;
    end
    while (sample_o !== 1'b1 && k < 2000) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k >= 2000) miscompares++;
  endtask : wait_samp

  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial begin
    #320000;
    miscompares++;
    print_verdict();
  end

  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    deep_sleep_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(sass_pkg::ADDR_LIM_HI, d); check(d, 32'hFFF);
    rd(sass_pkg::ADDR_CHEN, d); check(d, 32'h0);
    rd(sass_pkg::ADDR_STATUS, d); check(d, 32'h0);
    rd(8'hFC, d); check(d, 32'h0);
    check({scan_done_o, range_irq_o, sample_o, sar_clk_o}, 32'h0);
    foreach (ROWS[i]) begin
      wr(sass_pkg::ADDR_SAMPLE_BASE + {3'b000, ROWS[i].ch, 2'b00}, 32'(ROWS[i].ext));
      wr(sass_pkg::ADDR_LIM_LO, 32'(ROWS[i].lo));
      wr(sass_pkg::ADDR_LIM_HI, 32'(ROWS[i].hi));
      wr(sass_pkg::ADDR_CHEN, 32'h1 << ROWS[i].ch);
      wr(sass_pkg::ADDR_CTRL, 32'h1);
      poll(sass_pkg::ADDR_RESULT_BASE + {3'b000, ROWS[i].ch, 2'b00}, 16, 1'b1);
      check(d, {15'h0, 2'b10, ROWS[i].ch, lvl[ROWS[i].ch]});
      e = (lvl[ROWS[i].ch] < ROWS[i].lo) || (lvl[ROWS[i].ch] > ROWS[i].hi);
      rd(sass_pkg::ADDR_RANGE, d); check(d, 32'(e) << ROWS[i].ch);
      check(range_irq_o, 32'(e));
      wr(sass_pkg::ADDR_CTRL, 32'h0);
      poll(sass_pkg::ADDR_STATUS, 0, 1'b0);
      wr(sass_pkg::ADDR_RANGE, 32'hFF);
      @(negedge sys_clk_i);
      check(range_irq_o, 32'h0);
    end
    // Two far-apart channels with unlike sample times; the search wraps
    wr(sass_pkg::ADDR_STATUS, 32'h2);
    wr(sass_pkg::ADDR_CHEN, 32'h88);
    wr(sass_pkg::ADDR_CTRL, 32'h1);
    wait_samp(n); check(chan_sel_o, 32'h3);
    wait_samp(n); check(n, CONV + 2 * sass_pkg::SAR_DIV);
    check(chan_sel_o, 32'h7);
    check(scan_done_o, 32'h0);
    wait_samp(n); check(n, CONV);
    check(chan_sel_o, 32'h3);
    repeat (2) @(negedge sys_clk_i);
    check(scan_done_o, 32'h1);
    wr(sass_pkg::ADDR_CTRL, 32'h0);
    poll(sass_pkg::ADDR_STATUS, 0, 1'b0);
    wr(sass_pkg::ADDR_CTRL, 32'h3);
    // Drops the valid left by the earlier scan of this channel
    rd(sass_pkg::ADDR_RESULT_BASE + 8'h14, d);
    wr(sass_pkg::ADDR_FWSEL, 32'h105);
    poll(sass_pkg::ADDR_RESULT_BASE + 8'h14, 16, 1'b1);
    check(d, {15'h0, 2'b10, 3'h5, lvl[5]});
    poll(sass_pkg::ADDR_STATUS, 0, 1'b0);
    // Sleep lands in mid-sample: no result may appear
    wr(sass_pkg::ADDR_CTRL, 32'h1);
    wr(sass_pkg::ADDR_CHEN, 32'h10);
    wait_samp(n);
    @(posedge sys_clk_i);
    deep_sleep_i <= 1'b1;
    repeat (3) @(negedge sys_clk_i);
    check({sample_o, sar_clk_o}, 32'h0);
    rd(sass_pkg::ADDR_STATUS, d); check(d & 32'h81, 32'h80);
    rd(sass_pkg::ADDR_RESULT_BASE + 8'h10, d); check(d[16], 32'h0);
    wr(sass_pkg::ADDR_CTRL, 32'h0);
    deep_sleep_i <= 1'b0;
    poll(sass_pkg::ADDR_STATUS, 0, 1'b0);
    // Scan stalls on a full buffer; software drains it after the scan is disabled
    wr(sass_pkg::ADDR_CHEN, 32'h2);
    wr(sass_pkg::ADDR_CTRL, 32'h5);
    poll(sass_pkg::ADDR_STATUS, 0, 1'b0);
    check(d & 32'h61, 32'h60);
    wr(sass_pkg::ADDR_CTRL, 32'h0);
    for (int k = 0; k < sass_pkg::FIFO_DEPTH; k++) begin
      rd(sass_pkg::ADDR_FIFO, d); check(d[16:0], 32'h11800);
    end
    rd(sass_pkg::ADDR_FIFO, d); check(d[16], 32'h0);
    print_verdict();
  end

endmodule : sass_scan_seq_test

`default_nettype wire
